// ===== cae_pkg.sv
/*
 * Shared execute-unit constants and types.
 * Assumes a 16-bit word-addressed program counter.
 */
package cae_pkg;

    // Program counter and flag register
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [7:0] FLAGS_RESET = 8'h00;

    // Positions in the status_flags_register
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    // Flags touched by each instruction group
    localparam logic [7:0] MASK_ARITH = 8'h2F; // H V N Z C
    localparam logic [7:0] MASK_WORD = 8'h1F;  // S V N Z C
    localparam logic [7:0] MASK_LOGIC = 8'h0E; // V N Z
    localparam logic [7:0] MASK_NONE = 8'h00;
    localparam logic [7:0] MASK_ALL_ONES = 8'hFF;

    // Program counter steps
    localparam logic [15:0] PC_STEP_ONE = 16'h0001;
    localparam logic [15:0] PC_STEP_TWO = 16'h0002;
    localparam logic [15:0] PC_STEP_THREE = 16'h0003;

    // Cycle counts
    localparam logic [2:0] CYC_ONE = 3'h1;
    localparam logic [2:0] CYC_WORD = 3'h2;
    localparam logic [2:0] CYC_REL_JUMP = 3'h2;
    localparam logic [2:0] CYC_REL_CALL = 3'h3;
    localparam logic [2:0] CYC_IND_JUMP = 3'h2;
    localparam logic [2:0] CYC_IND_CALL = 3'h3;
    localparam logic [2:0] CYC_DIR_JUMP = 3'h3;
    localparam logic [2:0] CYC_DIR_CALL = 3'h4;
    localparam logic [2:0] CYC_RETURN = 3'h4;
    localparam logic [2:0] CYC_SKIP_ONE = 3'h2;
    localparam logic [2:0] CYC_SKIP_TWO = 3'h3;
    localparam logic [2:0] CYC_BR_TAKEN = 3'h2;

    typedef enum logic [3:0] {
        FN_ADD, FN_SUB, FN_AND, FN_OR, FN_XOR, FN_INC, FN_DEC,
        FN_WADD, FN_WSUB, FN_NONE
    } cae_alu_fn_t;

    typedef enum logic [5:0] {
        OP_ADD, OP_ADD_CARRY, OP_WORD_ADD_IMMEDIATE, OP_WORD_SUB_IMMEDIATE,
        OP_SUB, OP_SUB_CONST, OP_SUB_WITH_BORROW, OP_SUB_CONST_WITH_BORROW,
        OP_AND, OP_AND_CONST, OP_OR, OP_OR_CONST, OP_XOR_REGS,
        OP_SET_REG_BITS, OP_CLEAR_REG_BITS, OP_INC, OP_DEC,
        OP_ZERO_MINUS_TEST, OP_CLEAR_REG,
        OP_RELATIVE_JUMP, OP_RELATIVE_CALL, OP_INDIRECT_JUMP,
        OP_INDIRECT_CALL, OP_DIRECT_JUMP, OP_DIRECT_CALL,
        OP_SUBROUTINE_RETURN, OP_INTERRUPT_RETURN,
        OP_COMPARE_SKIP_EQUAL, OP_COMPARE, OP_COMPARE_WITH_CARRY,
        OP_COMPARE_IMMEDIATE, OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET,
        OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET,
        OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR,
        OP_BRANCH_EQUAL, OP_BRANCH_NOT_EQUAL
    } cae_op_t;

endpackage : cae_pkg

// ===== cae_alu.sv
/*
 * Combinational byte and word ALU with fresh flags.
 * Assumes the caller masks which flags land.
 */
`timescale 1ns/1ns
module cae_alu import cae_pkg::*; (
    // Function and operands
    input cae_alu_fn_t fn_in,
    input logic [7:0] a_in,
    input logic [7:0] b_in,
    input logic [15:0] word_in,
    input logic carry_in,
    // Zero chaining for borrow forms
    input logic zero_in,
    input logic keep_zero_in,
    // Results
    output logic [7:0] res_out,
    output logic [15:0] word_res_out,
    output logic [7:0] flags_out
);
    logic [8:0] sum9;
    logic [8:0] dif9;
    logic [16:0] wsum;
    logic [16:0] wdif;
    logic c;
    logic h;
    logic v;
    logic n;
    logic z;

    // Wide sums keep the carry out of bit 7 or 15
    assign sum9 = {1'b0, a_in} + {1'b0, b_in} + {8'h00, carry_in};
    assign dif9 = {1'b0, a_in} - {1'b0, b_in} - {8'h00, carry_in};
    assign wsum = {1'b0, word_in} + {9'h000, b_in};
    assign wdif = {1'b0, word_in} - {9'h000, b_in};

    // Result and flag terms per function
    always_comb begin
        res_out = 8'h00;
        word_res_out = 16'h0000;
        c = 1'b0;
        h = 1'b0;
        v = 1'b0;
        case (fn_in)
            FN_ADD: begin
                res_out = sum9[7:0];
                c = sum9[8];
                h = (a_in[3] & b_in[3]) | (b_in[3] & ~res_out[3])
                    | (~res_out[3] & a_in[3]);
                v = (a_in[7] & b_in[7] & ~res_out[7])
                    | (~a_in[7] & ~b_in[7] & res_out[7]);
            end
            FN_SUB: begin
                res_out = dif9[7:0];
                c = dif9[8];
                h = (~a_in[3] & b_in[3]) | (b_in[3] & res_out[3])
                    | (res_out[3] & ~a_in[3]);
                v = (a_in[7] & ~b_in[7] & ~res_out[7])
                    | (~a_in[7] & b_in[7] & res_out[7]);
            end
            FN_AND: res_out = a_in & b_in;
            FN_OR: res_out = a_in | b_in;
            FN_XOR: res_out = a_in ^ b_in;
            FN_INC: begin
                res_out = a_in + 8'h01;
                v = (res_out == 8'h80);
            end
            FN_DEC: begin
                res_out = a_in - 8'h01;
                v = (res_out == 8'h7F);
            end
            FN_WADD: begin
                word_res_out = wsum[15:0];
                c = wsum[16];
                v = ~word_in[15] & word_res_out[15];
            end
            FN_WSUB: begin
                word_res_out = wdif[15:0];
                c = wdif[16];
                v = word_in[15] & ~word_res_out[15];
            end
            default: res_out = 8'h00;
        endcase
    end

    // Word forms judge sign and zero on all sixteen bits
    wire word_fn = fn_in inside {FN_WADD, FN_WSUB};
    assign n = word_fn ? word_res_out[15] : res_out[7];
    assign z = word_fn ? (word_res_out == 16'h0000)
               : ((res_out == 8'h00) & (~keep_zero_in | zero_in));

    // Pack flags at their positions
    always_comb begin
        flags_out = 8'h00;
        flags_out[FLAG_C] = c;
        flags_out[FLAG_Z] = z;
        flags_out[FLAG_N] = n;
        flags_out[FLAG_V] = v;
        flags_out[FLAG_S] = n ^ v;
        flags_out[FLAG_H] = h;
    end

endmodule : cae_alu

// ===== cae_execute_unit.sv
/*
 * Execute stage: ALU, jumps, skips, branches, PC and status flags.
 * Assumes fetch gives decoded ops, ready operands and the popped PC.
 */
// What this block does
// - Byte add, carry form too, one cycle.
// - Word add or subtract constant, two cycles.
// - Byte subtract, borrow forms too, one cycle.
// - AND, OR and XOR, one cycle, Z N V.
// - Increment, decrement, test, clear, one cycle.
// - Set bits by OR, clear by AND with 0xFF minus mask.
// - Relative jump two cycles, call three with push.
// - Indirect jump and call from Z, two and three.
// - Direct jump three, call and returns four; I set on interrupt return.
// - Skip next when two registers are equal.
// - Compare by subtraction, result dropped.
// - Skip on working register bit.
// - Skip on I/O register bit.
// - Branch on chosen flag set or clear.
// - Branch on Z set or clear.
`timescale 1ns/1ns
module cae_execute_unit import cae_pkg::*; (
    // Clock and reset
    input logic ref_clk_in,
    input logic rst_n_in,
    // Instruction handshake
    input logic op_valid_in,
    input cae_op_t op_code_in,
    output logic ready_out,
    // Operands
    input logic [7:0] rd_val_in,
    input logic [7:0] rr_val_in,
    input logic [7:0] imm_in,
    input logic [15:0] word_val_in,
    input logic [2:0] bit_sel_in,
    input logic [7:0] io_val_in,
    input logic [2:0] flag_sel_in,
    input logic [15:0] offset_in,
    input logic [15:0] abs_target_in,
    input logic [15:0] z_ptr_in,
    input logic [15:0] stack_pc_in,
    input logic next_two_word_in,
    // Register file write-back
    output logic [7:0] result_out,
    output logic [15:0] result_word_out,
    output logic result_we_out,
    output logic word_we_out,
    // Stack
    output logic push_out,
    output logic [15:0] push_data_out,
    output logic pop_out,
    // Core state
    output logic [15:0] pc_out,
    output logic [7:0] flags_out,
    output logic done_out,
    output logic [2:0] cycles_out
);
    typedef enum logic {ST_READY, ST_WAIT} cae_state_t;

    function automatic cae_alu_fn_t op_fn(input cae_op_t op);
        case (op)
            OP_ADD, OP_ADD_CARRY: op_fn = FN_ADD;
            OP_WORD_ADD_IMMEDIATE: op_fn = FN_WADD;
            OP_WORD_SUB_IMMEDIATE: op_fn = FN_WSUB;
            OP_SUB, OP_SUB_CONST, OP_SUB_WITH_BORROW,
            OP_SUB_CONST_WITH_BORROW, OP_COMPARE, OP_COMPARE_WITH_CARRY,
            OP_COMPARE_IMMEDIATE: op_fn = FN_SUB;
            OP_AND, OP_AND_CONST, OP_CLEAR_REG_BITS,
            OP_ZERO_MINUS_TEST: op_fn = FN_AND;
            OP_OR, OP_OR_CONST, OP_SET_REG_BITS: op_fn = FN_OR;
            OP_XOR_REGS, OP_CLEAR_REG: op_fn = FN_XOR;
            OP_INC: op_fn = FN_INC;
            OP_DEC: op_fn = FN_DEC;
            default: op_fn = FN_NONE;
        endcase
    endfunction : op_fn

    // Flags each operation may change; all others hold except I on interrupt return
    function automatic logic [7:0] op_mask(input cae_op_t op);
        case (op_fn(op))
            FN_ADD, FN_SUB: op_mask = MASK_ARITH;
            FN_WADD, FN_WSUB: op_mask = MASK_WORD;
            FN_AND, FN_OR, FN_XOR, FN_INC, FN_DEC: op_mask = MASK_LOGIC;
            default: op_mask = MASK_NONE;
        endcase
    endfunction : op_mask

    cae_state_t state_reg, state_next;
    logic [2:0] cnt_reg, cnt_next;
    logic [15:0] pc_reg;
    logic [7:0] flags_reg;

    wire take = op_valid_in & (state_reg == ST_READY);
    wire uses_imm = op_code_in inside {OP_SUB_CONST,
        OP_SUB_CONST_WITH_BORROW, OP_AND_CONST, OP_OR_CONST,
        OP_SET_REG_BITS, OP_COMPARE_IMMEDIATE, OP_WORD_ADD_IMMEDIATE,
        OP_WORD_SUB_IMMEDIATE};
    wire uses_carry = op_code_in inside {OP_ADD_CARRY, OP_SUB_WITH_BORROW,
        OP_SUB_CONST_WITH_BORROW, OP_COMPARE_WITH_CARRY};
    wire is_compare = op_code_in inside {OP_COMPARE, OP_COMPARE_WITH_CARRY,
        OP_COMPARE_IMMEDIATE};
    wire self_operand = op_code_in inside {OP_ZERO_MINUS_TEST, OP_CLEAR_REG};
    wire is_word = op_code_in inside {OP_WORD_ADD_IMMEDIATE,
        OP_WORD_SUB_IMMEDIATE};
    wire is_skip = op_code_in inside {OP_COMPARE_SKIP_EQUAL,
        OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR,
        OP_SKIP_IO_BIT_SET};
    wire is_branch = op_code_in inside {OP_BRANCH_FLAG_SET,
        OP_BRANCH_FLAG_CLEAR, OP_BRANCH_EQUAL, OP_BRANCH_NOT_EQUAL};
    wire is_return = op_code_in inside {OP_SUBROUTINE_RETURN,
        OP_INTERRUPT_RETURN};
    wire is_call = op_code_in inside {OP_RELATIVE_CALL, OP_INDIRECT_CALL,
        OP_DIRECT_CALL};
    wire [7:0] op_mask_w = op_mask(op_code_in);
    wire writes_byte = (op_mask_w != MASK_NONE) & ~is_compare & ~is_word;

    // Clear mask is 0xFF minus constant
    wire [7:0] alu_b = self_operand ? rd_val_in
        : (op_code_in == OP_CLEAR_REG_BITS) ? (MASK_ALL_ONES - imm_in)
        : uses_imm ? imm_in : rr_val_in;
    // Carry only for carry and borrow forms
    wire alu_cin = uses_carry & flags_reg[FLAG_C];
    // Borrow forms chain Z across bytes
    wire keep_zero = uses_carry & (op_code_in != OP_ADD_CARRY);

    logic [7:0] alu_res;
    logic [15:0] alu_word;
    logic [7:0] alu_flags;

    // Shared adder, subtractor and logic unit
    cae_alu u_alu (
        .fn_in(op_fn(op_code_in)),
        .a_in(rd_val_in),
        .b_in(alu_b),
        .word_in(word_val_in),
        .carry_in(alu_cin),
        .zero_in(flags_reg[FLAG_Z]),
        .keep_zero_in(keep_zero),
        .res_out(alu_res),
        .word_res_out(alu_word),
        .flags_out(alu_flags)
    );

    wire reg_bit = rr_val_in[bit_sel_in];
    wire io_bit = io_val_in[bit_sel_in];
    wire skip_go =
        ((op_code_in == OP_COMPARE_SKIP_EQUAL) & (rd_val_in == rr_val_in))
        | ((op_code_in == OP_SKIP_REG_BIT_CLEAR) & ~reg_bit)
        | ((op_code_in == OP_SKIP_REG_BIT_SET) & reg_bit)
        | ((op_code_in == OP_SKIP_IO_BIT_CLEAR) & ~io_bit)
        | ((op_code_in == OP_SKIP_IO_BIT_SET) & io_bit);

    wire sel_flag = flags_reg[flag_sel_in];
    wire branch_go =
        ((op_code_in == OP_BRANCH_FLAG_SET) & sel_flag)
        | ((op_code_in == OP_BRANCH_FLAG_CLEAR) & ~sel_flag)
        // Equal tests Z set, not-equal Z clear
        | ((op_code_in == OP_BRANCH_EQUAL) & flags_reg[FLAG_Z])
        | ((op_code_in == OP_BRANCH_NOT_EQUAL) & ~flags_reg[FLAG_Z]);

    // Program counter candidates
    wire [15:0] pc_plus1 = pc_reg + PC_STEP_ONE;
    wire [15:0] rel_target = pc_reg + offset_in + PC_STEP_ONE;
    wire [15:0] skip_target = pc_reg
        + (next_two_word_in ? PC_STEP_THREE : PC_STEP_TWO);
    wire rel_go = (op_code_in inside {OP_RELATIVE_JUMP, OP_RELATIVE_CALL})
        | branch_go;
    wire ind_go = op_code_in inside {OP_INDIRECT_JUMP, OP_INDIRECT_CALL};
    wire dir_go = op_code_in inside {OP_DIRECT_JUMP, OP_DIRECT_CALL};

    // Relative target is PC plus offset plus one
    wire [15:0] pc_target = is_return ? stack_pc_in
        : ind_go ? z_ptr_in
        : dir_go ? abs_target_in
        : rel_go ? rel_target
        : (is_skip & skip_go) ? skip_target
        : pc_plus1;

    // Direct call returns past its second word
    wire [15:0] return_addr = (op_code_in == OP_DIRECT_CALL)
        ? pc_reg + PC_STEP_TWO : pc_plus1;

    // Cycle cost by class and outcome
    wire [2:0] op_cycles =
        is_word ? CYC_WORD
        : (op_code_in == OP_RELATIVE_JUMP) ? CYC_REL_JUMP
        : (op_code_in == OP_RELATIVE_CALL) ? CYC_REL_CALL
        : (op_code_in == OP_INDIRECT_JUMP) ? CYC_IND_JUMP
        : (op_code_in == OP_INDIRECT_CALL) ? CYC_IND_CALL
        : (op_code_in == OP_DIRECT_JUMP) ? CYC_DIR_JUMP
        : (op_code_in == OP_DIRECT_CALL) ? CYC_DIR_CALL
        : is_return ? CYC_RETURN
        : (is_skip & skip_go) ? (next_two_word_in ? CYC_SKIP_TWO
                                                  : CYC_SKIP_ONE)
        : branch_go ? CYC_BR_TAKEN
        : CYC_ONE;

    wire [7:0] flags_merged = (flags_reg & ~op_mask_w)
        | (alu_flags & op_mask_w);
    wire [7:0] flags_upd = (op_code_in == OP_INTERRUPT_RETURN)
        ? (flags_merged | (8'h01 << FLAG_I)) : flags_merged;

    // Sequencer: accept cycle counts as the first cycle
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        if (state_reg == ST_READY) begin
            if (take && op_cycles != CYC_ONE) begin
                state_next = ST_WAIT;
                cnt_next = op_cycles - CYC_ONE;
            end
        end else begin
            cnt_next = cnt_reg - CYC_ONE;
            if (cnt_reg == CYC_ONE) begin
                state_next = ST_READY;
            end
        end
    end

    // State and counter
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= ST_READY;
            cnt_reg <= 3'h0;
            done_out <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            done_out <= (take && op_cycles == CYC_ONE)
                || (state_reg == ST_WAIT && cnt_reg == CYC_ONE);
        end
    end

    // PC and flags commit at accept
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pc_reg <= PC_RESET;
            flags_reg <= FLAGS_RESET;
            cycles_out <= 3'h0;
        end else if (take) begin
            pc_reg <= pc_target;
            flags_reg <= flags_upd;
            cycles_out <= op_cycles;
        end
    end

    // Write-back and stack strobes, one cycle each
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            result_out <= 8'h00;
            result_word_out <= 16'h0000;
            result_we_out <= 1'b0;
            word_we_out <= 1'b0;
            push_out <= 1'b0;
            push_data_out <= 16'h0000;
            pop_out <= 1'b0;
        end else begin
            result_we_out <= take & writes_byte;
            // Word result written as a pair
            word_we_out <= take & is_word;
            push_out <= take & is_call;
            pop_out <= take & is_return;
            if (take) begin
                result_out <= alu_res;
                result_word_out <= alu_word;
                push_data_out <= return_addr;
            end
        end
    end

    // Outputs
    assign ready_out = (state_reg == ST_READY);
    assign pc_out = pc_reg;
    assign flags_out = flags_reg;

endmodule : cae_execute_unit

// ===== cae_execute_checker.sv
/*
 * Port checks for the execute unit.
 * Assumes one clock and an async active-low reset at the top module.
 */
`timescale 1ns/1ns
module cae_execute_checker import cae_pkg::*; (
    // Clock and reset
    input logic ref_clk_in,
    input logic rst_n_in,
    // Request side
    input logic op_valid_in,
    input cae_op_t op_code_in,
    input logic ready_out,
    input logic [7:0] rd_val_in,
    input logic [7:0] rr_val_in,
    input logic [2:0] flag_sel_in,
    input logic [15:0] offset_in,
    input logic [15:0] abs_target_in,
    input logic [15:0] stack_pc_in,
    input logic next_two_word_in,
    // Answer side
    input logic [7:0] result_out,
    input logic result_we_out,
    input logic push_out,
    input logic [15:0] push_data_out,
    input logic pop_out,
    input logic [15:0] pc_out,
    input logic [7:0] flags_out,
    input logic done_out,
    input logic [2:0] cycles_out
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // Request accepted at this edge
    wire take = op_valid_in && ready_out;

    a_add_result: assert property (
        take && op_code_in == OP_ADD |=> result_we_out && done_out
        && result_out == 8'($past(rd_val_in) + $past(rr_val_in)))
        else $error("add wrong");
    a_logic_keep: assert property (
        take && op_code_in inside {OP_AND, OP_AND_CONST, OP_OR, OP_INC,
        OP_OR_CONST, OP_XOR_REGS, OP_DEC} |=> (flags_out & ~MASK_LOGIC)
        == ($past(flags_out) & ~MASK_LOGIC))
        else $error("unlisted flag changed");
    a_word_cost: assert property (
        take && op_code_in inside {OP_WORD_ADD_IMMEDIATE,
        OP_WORD_SUB_IMMEDIATE} |=> !ready_out ##1 ready_out && done_out
        && cycles_out == CYC_WORD)
        else $error("word cost wrong");
    a_call_push: assert property (
        take && op_code_in == OP_DIRECT_CALL |=> push_out && !ready_out
        && pc_out == $past(abs_target_in)
        && push_data_out == $past(pc_out) + PC_STEP_TWO
        ##1 !ready_out [*2] ##1 done_out && cycles_out == CYC_DIR_CALL)
        else $error("direct call wrong");
    a_iret_flag: assert property (
        take && op_code_in == OP_INTERRUPT_RETURN |=> pop_out
        && flags_out[FLAG_I] && pc_out == $past(stack_pc_in) ##3 done_out)
        else $error("interrupt return wrong");
    a_branch_taken: assert property (
        take && op_code_in == OP_BRANCH_FLAG_SET && flags_out[flag_sel_in]
        |=> pc_out == $past(pc_out) + $past(offset_in) + PC_STEP_ONE
        && !done_out ##1 done_out && cycles_out == CYC_BR_TAKEN)
        else $error("taken branch wrong");
    a_branch_idle: assert property (
        take && op_code_in == OP_BRANCH_FLAG_CLEAR && flags_out[flag_sel_in]
        |=> pc_out == $past(pc_out) + PC_STEP_ONE && ready_out && done_out
        && cycles_out == CYC_ONE)
        else $error("untaken branch wrong");
    a_skip_equal: assert property (
        take && op_code_in == OP_COMPARE_SKIP_EQUAL
        && rd_val_in == rr_val_in |=> !ready_out && pc_out == $past(pc_out)
        + ($past(next_two_word_in) ? PC_STEP_THREE : PC_STEP_TWO))
        else $error("skip wrong");
endmodule : cae_execute_checker

bind cae_execute_unit cae_execute_checker chk (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .op_valid_in(op_valid_in), .op_code_in(op_code_in),
    .ready_out(ready_out), .rd_val_in(rd_val_in), .rr_val_in(rr_val_in),
    .flag_sel_in(flag_sel_in), .offset_in(offset_in),
    .abs_target_in(abs_target_in), .stack_pc_in(stack_pc_in),
    .next_two_word_in(next_two_word_in), .result_out(result_out),
    .result_we_out(result_we_out), .push_out(push_out),
    .push_data_out(push_data_out), .pop_out(pop_out), .pc_out(pc_out),
    .flags_out(flags_out), .done_out(done_out), .cycles_out(cycles_out));

// ===== cae_fetch_model.sv
/*
 * Fetch side model: presents one decoded operation at a time.
 * Assumes ready is settled one time unit after each rising edge.
 */
`timescale 1ns/1ns
module cae_fetch_model import cae_pkg::*; (
    // Clock and reset
    input logic ref_clk_in,
    input logic rst_n_in,
    // Handshake
    input logic ready_in,
    output logic op_valid_out,
    output cae_op_t op_code_out
);
    initial begin
        op_valid_out = 1'b0;
        op_code_out = OP_ADD;
    end

    // Hold request until ready; gap is slow fetch
    task automatic send(input cae_op_t op, input int gap, output bit ok);
        int n;
        ok = 1'b0;
        repeat (gap + 1) begin
            @(posedge ref_clk_in);
            #1;
        end
        op_valid_out = 1'b1;
        op_code_out = op;
        for (n = 0; n < 8 && !ok; n++) begin
            ok = (ready_in === 1'b1) && rst_n_in;
            @(posedge ref_clk_in);
            #1;
        end
        op_valid_out = 1'b0;
        // Stale code hides valid bugs
        op_code_out = op.next();
    endtask : send
endmodule : cae_fetch_model

// ===== cae_execute_unit_tb_top.sv
/*
 * Execute unit bench.
 * Assumes the checker is bound in.
 */
`timescale 1ns/1ns
module cae_execute_unit_tb_top import cae_pkg::*;;
    localparam logic [7:0] FL = 8'h15;
    logic clk, rst_n, valid, we, wwe, push, pop, done, ready, two;
    cae_op_t code;
    logic [7:0] rd, rr, imm, io, res, fl;
    logic [2:0] bsel, fsel, cyc;
    logic [15:0] wv, off, abst, zp, spc, wres, pdat, pc, exp_pc;
    int failures, n_checks;

    cae_fetch_model fm (.ref_clk_in(clk), .rst_n_in(rst_n),
        .ready_in(ready), .op_valid_out(valid), .op_code_out(code));
    cae_execute_unit dut (.ref_clk_in(clk), .rst_n_in(rst_n),
        .op_valid_in(valid), .op_code_in(code), .ready_out(ready),
        .rd_val_in(rd), .rr_val_in(rr), .imm_in(imm), .word_val_in(wv),
        .bit_sel_in(bsel), .io_val_in(io), .flag_sel_in(fsel),
        .offset_in(off), .abs_target_in(abst), .z_ptr_in(zp),
        .stack_pc_in(spc), .next_two_word_in(two), .result_out(res),
        .result_word_out(wres), .result_we_out(we), .word_we_out(wwe),
        .push_out(push), .push_data_out(pdat), .pop_out(pop),
        .pc_out(pc), .flags_out(fl), .done_out(done), .cycles_out(cyc));

    task automatic end_sim();
        if (failures == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [15:0] e, g);
        n_checks++;
        if (e !== g) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Issue one op, bounded wait for done
    task automatic run(input cae_op_t op, input logic [2:0] c);
        bit ok;
        int n;
        fm.send(op, 0, ok);
        for (n = 0; n < 8 && done !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        if (!ok || done !== 1'b1) begin
            failures++;
            end_sim();
        end
        chk("cycles", 16'(c), 16'(cyc));
    endtask : run

    // One-cycle byte op; compares write nothing back
    task automatic alu(input cae_op_t op, input logic [7:0] a, b, k, r, f);
        logic w;
        w = !(op inside {OP_COMPARE, OP_COMPARE_WITH_CARRY,
            OP_COMPARE_IMMEDIATE});
        {rd, rr, imm} = {a, b, k};
        run(op, CYC_ONE);
        exp_pc = exp_pc + PC_STEP_ONE;
        if (w) chk("result", 16'(r), 16'(res));
        chk("write", 16'(w), 16'(we));
        chk("flags", 16'(f), 16'(fl));
        chk("pc", exp_pc, pc);
    endtask : alu

    task automatic direct_jump(input cae_op_t op, input logic [2:0] c,
        input logic [15:0] p);
        run(op, c);
        exp_pc = p;
        chk("pc", p, pc);
    endtask : direct_jump

    task automatic t_arith();
        alu(OP_ADD, 8'h0F, 8'h01, 8'h00, 8'h10, 8'h20);
        alu(OP_ADD, 8'hFF, 8'h01, 8'h00, 8'h00, 8'h23);
        alu(OP_ADD_CARRY, 8'h01, 8'h01, 8'h00, 8'h03, 8'h00);
        alu(OP_SUB, 8'h00, 8'h01, 8'h00, 8'hFF, 8'h25);
        alu(OP_SUB_WITH_BORROW, 8'h05, 8'h04, 8'h00, 8'h00, 8'h00);
        alu(OP_SUB_CONST, 8'h10, 8'h00, 8'h01, 8'h0F, 8'h20);
        alu(OP_SUB_CONST_WITH_BORROW, 0, 0, 1, 8'hFF, 8'h25);
        alu(OP_COMPARE_IMMEDIATE, 8'h80, 0, 8'h01, 0, 8'h28);
        alu(OP_COMPARE, 8'h42, 8'h42, 0, 0, 8'h02);
        alu(OP_COMPARE_WITH_CARRY, 8'h10, 8'h10, 0, 0, 8'h02);
    endtask : t_arith

    task automatic t_logic();
        alu(OP_AND_CONST, 8'hF0, 0, 8'h80, 8'h80, 8'h04);
        alu(OP_CLEAR_REG_BITS, 8'hFF, 0, 8'h0F, 8'hF0, 8'h04);
        alu(OP_SET_REG_BITS, 8'h01, 0, 8'h80, 8'h81, 8'h04);
        alu(OP_OR, 8'h00, 8'h00, 0, 8'h00, 8'h02);
        alu(OP_OR_CONST, 8'h10, 0, 8'h01, 8'h11, 8'h00);
        alu(OP_AND, 8'h0F, 8'hF0, 0, 8'h00, 8'h02);
        alu(OP_XOR_REGS, 8'h5A, 8'hA5, 0, 8'hFF, 8'h04);
        alu(OP_ZERO_MINUS_TEST, 8'h00, 0, 0, 8'h00, 8'h02);
        alu(OP_CLEAR_REG, 8'h77, 0, 0, 8'h00, 8'h02);
        alu(OP_INC, 8'h7F, 0, 0, 8'h80, 8'h0C);
        alu(OP_DEC, 8'h80, 0, 0, 8'h7F, 8'h08);
    endtask : t_logic

    task automatic t_word();
        wv = 16'hFFFF;
        imm = 8'h01;
        run(OP_WORD_ADD_IMMEDIATE, CYC_WORD);
        chk("word", 16'h0000, wres);
        chk("flags", 16'h0003, 16'(fl));
        wv = 16'h0000;
        run(OP_WORD_SUB_IMMEDIATE, CYC_WORD);
        chk("word", 16'hFFFF, wres);
        chk("flags", 16'h0015, 16'(fl));
        exp_pc = exp_pc + PC_STEP_TWO;
        chk("pc", exp_pc, pc);
    endtask : t_word

    // Every flag index, both polarities
    task automatic t_branch();
        int i;
        logic t;
        off = 16'h0004;
        for (i = 0; i < 16; i++) begin
            fsel = i[2:0];
            t = FL[i[2:0]] ^ i[3];
            direct_jump(i[3] ? OP_BRANCH_FLAG_CLEAR : OP_BRANCH_FLAG_SET,
                t ? CYC_BR_TAKEN : CYC_ONE,
                exp_pc + (t ? 16'h0005 : 16'h0001));
        end
        direct_jump(OP_BRANCH_EQUAL, CYC_ONE, exp_pc + PC_STEP_ONE);
        direct_jump(OP_BRANCH_NOT_EQUAL, CYC_BR_TAKEN, exp_pc + 16'h0005);
    endtask : t_branch

    task automatic t_skip();
        rr = 8'h08;
        bsel = 3'h3;
        direct_jump(OP_SKIP_REG_BIT_SET, CYC_SKIP_ONE, exp_pc + 16'h0002);
        direct_jump(OP_SKIP_REG_BIT_CLEAR, CYC_ONE, exp_pc + 16'h0001);
        io = 8'h7F;
        bsel = 3'h7;
        two = 1'b1;
        direct_jump(OP_SKIP_IO_BIT_CLEAR, CYC_SKIP_TWO, exp_pc + 16'h0003);
        direct_jump(OP_SKIP_IO_BIT_SET, CYC_ONE, exp_pc + 16'h0001);
        rd = 8'h33;
        rr = 8'h33;
        direct_jump(OP_COMPARE_SKIP_EQUAL, CYC_SKIP_TWO, exp_pc + 16'h0003);
        rd = 8'h34;
        direct_jump(OP_COMPARE_SKIP_EQUAL, CYC_ONE, exp_pc + 16'h0001);
        chk("flags", 16'(FL), 16'(fl));
    endtask : t_skip

    task automatic t_flow();
        bit ok;
        off = 16'h0010;
        direct_jump(OP_RELATIVE_JUMP, CYC_REL_JUMP, exp_pc + 16'h0011);
        direct_jump(OP_RELATIVE_CALL, CYC_REL_CALL, exp_pc + 16'h0011);
        chk("push", exp_pc - 16'h0010, pdat);
        zp = 16'h1234;
        direct_jump(OP_INDIRECT_JUMP, CYC_IND_JUMP, zp);
        zp = 16'h2000;
        direct_jump(OP_INDIRECT_CALL, CYC_IND_CALL, zp);
        chk("push", 16'h1235, pdat);
        abst = 16'h0300;
        direct_jump(OP_DIRECT_JUMP, CYC_DIR_JUMP, abst);
        abst = 16'h0400;
        // Call, then a jump while busy
        fm.send(OP_DIRECT_CALL, 0, ok);
        chk("call", 16'h0001, 16'(ok));
        chk("push", 16'h0302, pdat);
        direct_jump(OP_RELATIVE_JUMP, CYC_REL_JUMP, 16'h0411);
        spc = 16'h0050;
        direct_jump(OP_SUBROUTINE_RETURN, CYC_RETURN, spc);
        spc = 16'h0060;
        direct_jump(OP_INTERRUPT_RETURN, CYC_RETURN, spc);
        chk("flags", 16'h0095, 16'(fl));
    endtask : t_flow

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        rst_n = 1'b0;
        {rd, rr, imm, io, bsel, fsel, two} = '0;
        {wv, off, abst, zp, spc, exp_pc} = '0;
        failures = 0;
        n_checks = 0;
        repeat (2) @(posedge clk);
        #1;
        rst_n = 1'b1;
        chk("pc", PC_RESET, pc);
        chk("flags", 16'(FLAGS_RESET), 16'(fl));
        t_arith();
        t_logic();
        t_word();
        t_branch();
        t_skip();
        t_flow();
        end_sim();
    end
endmodule : cae_execute_unit_tb_top
